//--- src/clk_switch_pkg.sv
// package for the fail-safe clock switch: register map, field layout, group codes
// assumes a 32-bit Avalon-MM slave port addressed in bytes
package clk_switch_pkg;

  // ==========================================================================
  // register map
  localparam logic [3:0]  ADDR_CTRL   = 4'h0;
  localparam logic [3:0]  ADDR_STATUS = 4'h4;
  localparam logic [15:0] CTRL_RESET  = 16'h0000;

  // ==========================================================================
  // control register fields
  localparam int CUR_LSB  = 12;
  localparam int NEW_LSB  = 8;
  localparam int LOCK_BIT = 5;
  localparam int CF_BIT   = 3;
  localparam int REQ_BIT  = 0;

  // ==========================================================================
  // unlock keys, low byte then high byte
  localparam logic [7:0] LO_KEY1 = 8'h46;
  localparam logic [7:0] LO_KEY2 = 8'h57;
  localparam logic [7:0] HI_KEY1 = 8'h78;
  localparam logic [7:0] HI_KEY2 = 8'h9A;

  // ==========================================================================
  // oscillator groups
  typedef logic [1:0] group_type;
  localparam group_type GRP_SECONDARY = 2'h0;
  localparam group_type GRP_FRC       = 2'h1;
  localparam group_type GRP_LOW_POWER_RC_OSC      = 2'h2;
  localparam group_type GRP_PRIMARY   = 2'h3;

  // ==========================================================================
  // monitor window in low-power rc edges
  localparam int FAIL_WINDOW_DEF = 4;

  // ==========================================================================
  // switch sequencer states
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_WAIT   = 3'b010,
    ST_COMMIT = 3'b100
  } sw_state_type;

  // ==========================================================================
  // configuration word pins
  typedef struct packed {
    logic [1:0] monitor_select_cfg;
    logic [1:0] boot_osc_cfg;
    logic [3:0] primary_osc_cfg;
  } cfg_type;

  // oscillator status pins
  typedef struct packed {
    logic [3:0] osc_ready;
    logic       pll_lock;
    logic       sys_osc_tick;
    logic       low_power_rc_osc_tick;
    logic       power_up_timer_done;
    logic       sleep_mode;
    logic       watchdog_sw_enable;
  } osc_pins_type;

endpackage : clk_switch_pkg

//--- src/fail_safe_clock_switch.sv
// clock-source supervision and group switching with fail-safe fallback
// assumes config word and oscillator status arrive as asynchronous pins,
// rst_n stands for power-on and brown-out reset
`timescale 1ns/1ps
`default_nettype none
// How it works
// RULE1: monitor enable follows monitor select field
// RULE2: low-power rc runs always except sleep; with the monitor off it follows the watchdog software enable instead
// RULE3: failure raises trap, moves to fast rc
// RULE4: failure loads fast rc, sets flag, clears request
// RULE5: watchdog clock untouched by clock failure
// RULE6: power-up timeout before start means failure
// RULE7: switching only between four groups
// RULE8: primary option comes from primary config field
// RULE9: current group read-only, shows actual group
// RULE10: software writes target into new group
// RULE11: reset loads current and new from boot
// RULE12: status bit reports pll lock
// RULE13: clock fail flag read-only, shows failure
// RULE14: request starts switch, clearing it aborts
// RULE15: select upper bit disables switch and monitor
// RULE16: switching disabled, boot config selects clock directly
// RULE17: software avoids clocks under 100 kHz
// RULE18: low byte needs 46h,57h unlock pair
// RULE19: high byte needs 78h,9Ah unlock pair
// RULE20: failure after window of rc edges
module fail_safe_clock_switch
  import clk_switch_pkg::*;
#(
  parameter int FAIL_WINDOW = FAIL_WINDOW_DEF
) (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire clk_switch_pkg::cfg_type      cfg_pins,
  input  wire clk_switch_pkg::osc_pins_type osc_pins,
  input  wire logic [3:0]                 address,
  input  wire logic                       read,
  input  wire logic                       write,
  input  wire logic [31:0]                writedata,
  input  wire logic [3:0]                 byteenable,
  output var  logic [31:0]                readdata,
  output var  logic                       waitrequest,
  output var  logic [1:0]                 clock_sel,
  output var  logic [3:0]                 primary_sel,
  output var  logic [3:0]                 osc_enable,
  output var  logic                       low_power_rc_osc_run,
  output var  logic                       clock_fail_trap
);
  import clk_switch_pkg::*;

  // ==========================================================================
  // parameter check
  if (FAIL_WINDOW < 2 || FAIL_WINDOW > 255)
  begin : g_bad_window
    $error("FAIL_WINDOW must lie in 2..255");
  end

  // ==========================================================================
  // input synchronisers
  cfg_type      cfg_s;
  osc_pins_type pin_s;

  // synchronisers run through reset so boot load reads settled pins
  sync_two_stage #(.WIDTH($bits(cfg_type))) u_sync_cfg (
    .clk   (clk),
    .d     (cfg_pins),
    .q     (cfg_s)
  );

  sync_two_stage #(.WIDTH($bits(osc_pins_type))) u_sync_osc (
    .clk   (clk),
    .d     (osc_pins),
    .q     (pin_s)
  );

  // ==========================================================================
  // state
  group_type    cur_r;
  group_type    new_r;
  logic         req_r;
  logic         cf_r;
  logic         boot_load_r;
  logic [1:0]   lo_stage_r;
  logic [1:0]   hi_stage_r;
  logic [7:0]   miss_cnt_r;
  logic         sys_tick_d_r;
  logic         low_power_rc_osc_tick_d_r;
  logic         power_up_timer_d_r;
  sw_state_type state_r;
  sw_state_type state_nxt;

  // ==========================================================================
  // configuration decode
  // RULE1 monitor enable
  wire monitor_en = (cfg_s.monitor_select_cfg == 2'h0);
  // RULE15 upper bit off
  wire switch_en  = ~cfg_s.monitor_select_cfg[1];

  // ==========================================================================
  // bus decode
  wire acc      = (read | write) & ~waitrequest;
  wire wr_ctrl  = acc & write & (address == ADDR_CTRL);
  wire lo_lane  = wr_ctrl & byteenable[0];
  wire hi_lane  = wr_ctrl & byteenable[1];
  wire [7:0] lo_byte = writedata[7:0];
  wire [7:0] hi_byte = writedata[15:8];
  // RULE18 low byte open
  wire lo_open  = lo_lane & (lo_stage_r == 2'h2);
  // RULE19 high byte open
  wire hi_open  = hi_lane & (hi_stage_r == 2'h2);

  wire [1:0] lo_stage_nxt = !acc ? lo_stage_r :
                            !lo_lane ? 2'h0 :
                            (lo_stage_r == 2'h0 && lo_byte == LO_KEY1) ? 2'h1 :
                            (lo_stage_r == 2'h1 && lo_byte == LO_KEY2) ? 2'h2 : 2'h0;
  wire [1:0] hi_stage_nxt = !acc ? hi_stage_r :
                            !hi_lane ? 2'h0 :
                            (hi_stage_r == 2'h0 && hi_byte == HI_KEY1) ? 2'h1 :
                            (hi_stage_r == 2'h1 && hi_byte == HI_KEY2) ? 2'h2 : 2'h0;

  // ==========================================================================
  // failure monitor
  wire sys_edge  = pin_s.sys_osc_tick ^ sys_tick_d_r;
  wire low_power_rc_osc_edge = pin_s.low_power_rc_osc_tick ^ low_power_rc_osc_tick_d_r;
  wire power_up_timer_rise = pin_s.power_up_timer_done & ~power_up_timer_d_r;
  wire watching  = monitor_en & ~pin_s.sleep_mode & ~boot_load_r & (cur_r != GRP_FRC);
  // RULE20 missed edge window
  wire miss_fail = watching & low_power_rc_osc_edge & ~sys_edge
                   & (miss_cnt_r == 8'(FAIL_WINDOW - 1));
  // RULE6 slow start
  wire slow_fail = watching & power_up_timer_rise & ~pin_s.osc_ready[cur_r];
  wire fail      = miss_fail | slow_fail;

  wire [7:0] miss_cnt_nxt = (sys_edge | ~watching) ? 8'h00 :
                            low_power_rc_osc_edge ? miss_cnt_r + 8'h01 : miss_cnt_r;

  // ==========================================================================
  // switch sequencer
  wire commit = (state_r == ST_COMMIT) & req_r;

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE:   if (req_r && switch_en) state_nxt = ST_WAIT;
      ST_WAIT:   if (pin_s.osc_ready[new_r]) state_nxt = ST_COMMIT;
      ST_COMMIT: state_nxt = ST_IDLE;
      default:   state_nxt = ST_IDLE;
    endcase
    // RULE14 clearing aborts
    if (!req_r || fail || boot_load_r || !switch_en)
      state_nxt = ST_IDLE;
  end

  // RULE11 boot load
  // RULE16 direct selection
  // RULE3 move to fast rc
  // RULE7 whole groups only
  wire group_type cur_nxt = (boot_load_r || !switch_en) ? group_type'(cfg_s.boot_osc_cfg) :
                            fail ? GRP_FRC :
                            commit ? new_r : cur_r;
  // RULE10 software target
  wire group_type new_nxt = boot_load_r ? group_type'(cfg_s.boot_osc_cfg) :
                            hi_open ? group_type'(hi_byte[NEW_LSB-8 +: 2]) : new_r;
  // RULE4 request cleared on failure
  // RULE14 software set wins over commit clear
  wire req_nxt = (boot_load_r | fail) ? 1'b0 :
                 lo_open ? lo_byte[REQ_BIT] :
                 commit ? 1'b0 : req_r;
  // RULE13 sticky read-only flag
  wire cf_nxt  = cf_r | fail;

  // ==========================================================================
  // outputs
  // RULE2 rc kept running
  // RULE5 watchdog clock independent of failure
  wire low_power_rc_osc_run_nxt = monitor_en ? ~pin_s.sleep_mode : pin_s.watchdog_sw_enable;
  wire [3:0] cur_onehot = 4'h1 << cur_r;
  wire [3:0] new_onehot = (state_r != ST_IDLE) ? (4'h1 << new_r) : 4'h0;
  // RULE6 original oscillator off
  wire [3:0] osc_enable_nxt = (4'h1 << cur_nxt) | (fail ? 4'h0 : new_onehot);
  // RULE8 primary option
  wire [3:0] primary_sel_nxt = (cur_nxt == GRP_PRIMARY) ? cfg_s.primary_osc_cfg
                                                        : primary_sel;

  // RULE9 read-only group field
  // RULE12 lock status
  wire [15:0] ctrl_word = {2'h0, cur_r, 2'h0, new_r, 2'h0, pin_s.pll_lock,
                           1'b0, cf_r, 2'h0, req_r};
  wire [15:0] status_word = {9'h000, (state_r != ST_IDLE), low_power_rc_osc_run,
                             monitor_en, switch_en, cur_onehot[0], 2'h0};
  wire [31:0] rd_nxt = (address == ADDR_CTRL)   ? {16'h0000, ctrl_word} :
                       (address == ADDR_STATUS) ? {16'h0000, status_word} : 32'h0000_0000;
  wire wait_nxt = ~((read | write) & waitrequest);

  // ==========================================================================
  // registers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cur_r           <= GRP_FRC;
      new_r           <= GRP_FRC;
      req_r           <= CTRL_RESET[REQ_BIT];
      cf_r            <= CTRL_RESET[CF_BIT];
      boot_load_r     <= 1'b1;
      lo_stage_r      <= 2'h0;
      hi_stage_r      <= 2'h0;
      miss_cnt_r      <= 8'h00;
      sys_tick_d_r    <= 1'b0;
      low_power_rc_osc_tick_d_r   <= 1'b0;
      power_up_timer_d_r        <= 1'b0;
      state_r         <= ST_IDLE;
      readdata        <= 32'h0000_0000;
      waitrequest     <= 1'b1;
      clock_sel       <= GRP_FRC;
      primary_sel     <= 4'h0;
      osc_enable      <= 4'h0;
      low_power_rc_osc_run        <= 1'b0;
      clock_fail_trap <= 1'b0;
    end
    else
    begin
      cur_r           <= cur_nxt;
      new_r           <= new_nxt;
      req_r           <= req_nxt;
      cf_r            <= cf_nxt;
      boot_load_r     <= 1'b0;
      lo_stage_r      <= lo_stage_nxt;
      hi_stage_r      <= hi_stage_nxt;
      miss_cnt_r      <= miss_cnt_nxt;
      sys_tick_d_r    <= pin_s.sys_osc_tick;
      low_power_rc_osc_tick_d_r   <= pin_s.low_power_rc_osc_tick;
      power_up_timer_d_r        <= pin_s.power_up_timer_done;
      state_r         <= state_nxt;
      readdata        <= rd_nxt;
      waitrequest     <= wait_nxt;
      clock_sel       <= cur_nxt;
      primary_sel     <= primary_sel_nxt;
      osc_enable      <= osc_enable_nxt;
      low_power_rc_osc_run        <= low_power_rc_osc_run_nxt;
      // RULE3 trap pulse
      clock_fail_trap <= fail;
    end
  end

  // ==========================================================================
  // assertions
  property p_fail_frc;
    @(posedge clk) disable iff (!rst_n)
    fail && switch_en |=> cur_r == GRP_FRC && cf_r && !req_r && clock_fail_trap;
  endproperty
  a_fail_frc: assert property (p_fail_frc) // RULE4
    else $error("failure did not force fast rc group");

  property p_cf_sticky;
    @(posedge clk) disable iff (!rst_n)
    cf_r |=> cf_r;
  endproperty
  a_cf_sticky: assert property (p_cf_sticky) // RULE13
    else $error("clock fail flag dropped");

  property p_trap_cause;
    @(posedge clk) disable iff (!rst_n)
    $rose(clock_fail_trap) |-> $past(monitor_en) && $past(cur_r) != GRP_FRC;
  endproperty
  a_trap_cause: assert property (p_trap_cause) // RULE1
    else $error("trap without active monitor");

  property p_low_power_rc_osc_run;
    @(posedge clk) disable iff (!rst_n)
    rst_n && monitor_en && !pin_s.sleep_mode ##1 monitor_en |-> low_power_rc_osc_run;
  endproperty
  a_low_power_rc_osc_run: assert property (p_low_power_rc_osc_run) // RULE2
    else $error("rc oscillator stopped while monitoring");

  property p_boot_load;
    @(posedge clk) disable iff (!rst_n)
    rst_n && boot_load_r |=> cur_r == $past(cfg_s.boot_osc_cfg)
                             && new_r == $past(cfg_s.boot_osc_cfg);
  endproperty
  a_boot_load: assert property (p_boot_load) // RULE11
    else $error("reset did not load boot group");

  property p_direct;
    @(posedge clk) disable iff (!rst_n)
    rst_n && !switch_en ##1 !switch_en |-> cur_r == $past(cfg_s.boot_osc_cfg)
                                           && clock_sel == cur_r;
  endproperty
  a_direct: assert property (p_direct) // RULE16
    else $error("group not following boot config");

  property p_abort;
    @(posedge clk) disable iff (!rst_n)
    state_r != ST_IDLE && !req_r |=> state_r == ST_IDLE;
  endproperty
  a_abort: assert property (p_abort) // RULE14
    else $error("cleared request did not abort switch");

  property p_no_unlock;
    @(posedge clk) disable iff (!rst_n)
    lo_lane && lo_stage_r != 2'h2 && !fail && !commit && !boot_load_r |=> req_r == $past(req_r);
  endproperty
  a_no_unlock: assert property (p_no_unlock) // RULE18
    else $error("locked low byte was written");

  property p_wait_ack;
    @(posedge clk) disable iff (!rst_n)
    (read || write) && waitrequest |=> !waitrequest ##1 waitrequest;
  endproperty
  a_wait_ack: assert property (p_wait_ack)
    else $error("bus answer not one cycle late");

  property p_lock_read;
    @(posedge clk) disable iff (!rst_n)
    read && waitrequest && address == ADDR_CTRL |=> readdata[LOCK_BIT] == $past(pin_s.pll_lock);
  endproperty
  a_lock_read: assert property (p_lock_read) // RULE12
    else $error("lock bit misreported");

  c_fail:   cover property (@(posedge clk) disable iff (!rst_n) miss_fail);
  c_slow:   cover property (@(posedge clk) disable iff (!rst_n) slow_fail);
  c_switch: cover property (@(posedge clk) disable iff (!rst_n) commit);
  c_abort:  cover property (@(posedge clk) disable iff (!rst_n)
                            state_r == ST_WAIT ##1 state_r == ST_IDLE && !req_r);

endmodule : fail_safe_clock_switch
`default_nettype wire

//--- src/sync_two_stage.sv
// two flip-flop synchroniser for a bundle of level inputs
// assumes each bit is an independent slow level or toggle from outside clk,
// and that reset is held for at least two clocks so the chain is full at release
`timescale 1ns/1ps
`default_nettype none
module sync_two_stage #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic [WIDTH-1:0] d,
  output var  logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;

  // ==========================================================================
  // first stage feeds only the second
  // no reset: the chain fills while the block is held in reset, so the boot
  // load at release sees the real pins and not a cleared zero
  always_ff @(posedge clk)
  begin
    meta_r <= d;
    q      <= meta_r;
  end

endmodule : sync_two_stage
`default_nettype wire

//--- verif/osc_model.sv
// oscillator sources facing the clock switch: readiness, pll lock, edge ticks
// assumes osc_enable from the switch; dead and ready_dly come from the bench
`timescale 1ns/1ps
`default_nettype none
module osc_model (
  input  wire logic       clk,
  input  wire logic [3:0] osc_enable,
  input  wire logic       dead,
  input  wire logic [8:0] ready_dly,
  output var  logic [3:0] osc_ready,
  output var  logic       pll_lock,
  output var  logic       sys_tick,
  output var  logic       low_power_rc_osc_tick
);
  int cnt [4];
  int ph;
  initial
  begin
    cnt = '{default: 0};
    ph = 0;
    osc_ready = 4'h0;
    pll_lock = 1'b0;
    sys_tick = 1'b0;
    low_power_rc_osc_tick = 1'b0;
  end
  // ==========================================================================
  // sources
  always @(posedge clk)
  begin
    ph <= ph + 1;
    // source kept well above the slowest legal rate
    if (!dead && ph[0])
      sys_tick <= !sys_tick;
    if (ph[2:0] == 3'h0)
      low_power_rc_osc_tick <= !low_power_rc_osc_tick;
    // a source is ready only after its start-up delay, and drops once disabled
    for (int g = 0; g < 4; g++)
    begin
      cnt[g] <= osc_enable[g] ? cnt[g] + 1 : 0;
      osc_ready[g] <= osc_enable[g] && cnt[g] >= ready_dly;
    end
    pll_lock <= osc_ready[3];
  end
endmodule : osc_model
`default_nettype wire

//--- verif/testbench.sv
// self-checking bench for the fail-safe clock switch
// assumes osc_model as the far side and an Avalon-MM master in the bench
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import clk_switch_pkg::*;
  logic clk, rst_n, read, write, dead, power_up_timer, wdt, slp, low_power_rc_osc_run, trap;
  logic [3:0] address, byteenable, osc_enable, rdy, primary_sel, prim;
  logic [31:0] writedata, readdata, q;
  logic waitrequest, lock, stick, ltick;
  logic [1:0] clock_sel, g;
  logic [8:0] dly;
  cfg_type cfg_pins;
  osc_pins_type osc_pins;
  int errors, total_checks, cur, nxt, cf, req, n;
  assign osc_pins = {rdy, lock, stick, ltick, power_up_timer, slp, wdt};
  fail_safe_clock_switch #(.FAIL_WINDOW(2)) i_fail_safe_clock_switch (.clk(clk), .rst_n(rst_n),
    .cfg_pins(cfg_pins), .osc_pins(osc_pins), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .clock_sel(clock_sel), .primary_sel(primary_sel),
    .osc_enable(osc_enable), .low_power_rc_osc_run(low_power_rc_osc_run), .clock_fail_trap(trap));
  osc_model i_osc_model (.clk(clk), .osc_enable(osc_enable), .dead(dead), .ready_dly(dly),
    .osc_ready(rdy), .pll_lock(lock), .sys_tick(stick), .low_power_rc_osc_tick(ltick));
  always #25 clk = ~clk;
  // ==========================================================================
  // compare and bus tasks
  task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk_reg
  task automatic chk_pin(input string nm, input logic [3:0] e, input logic [3:0] s);
    total_checks++;
    if (s !== e)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk_pin
  // request held until the edge that samples waitrequest low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] r);
    int k;
    @(posedge clk);
    address <= a;
    writedata <= d;
    byteenable <= be;
    write <= wr;
    read <= !wr;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (waitrequest !== 1'b0 && k < 50);
    r = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (k == 50)
      chk_pin("waitrequest", 4'h0, {3'h0, waitrequest});
  endtask : bus
  task automatic w(input int lane, input logic [7:0] v);
    logic [31:0] r;
    bus(1'b1, ADDR_CTRL, 32'(v) << (8 * lane), 4'(1 << lane), r);
  endtask : w
  function automatic logic [31:0] ctrl_exp();
    return 32'((cur << 12) | (nxt << 8) | (cf << 3) | req);
  endfunction : ctrl_exp
  task automatic rd_ctrl();
    bus(1'b0, ADDR_CTRL, 32'h0, 4'hF, q);
    chk_reg("ctrl", ctrl_exp(), q & ~32'h20);
  endtask : rd_ctrl
  // unlocked target write, then unlocked request write
  task automatic sw(input logic [1:0] t, input logic go);
    w(1, HI_KEY1);
    w(1, HI_KEY2);
    w(1, {6'h00, t});
    w(0, LO_KEY1);
    w(0, LO_KEY2);
    w(0, {7'h00, go});
    nxt = t;
    req = go;
  endtask : sw
  task automatic wait_sel(input logic [1:0] t);
    n = 0;
    while (clock_sel !== t && n < 600)
    begin
      @(posedge clk);
      n++;
    end
  endtask : wait_sel
  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim
  // ==========================================================================
  // tests
  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    end_sim();
  end
  initial
  begin
    clk = 0; rst_n = 0; read = 0; write = 0; address = 4'h0; writedata = 32'h0;
    byteenable = 4'h0; dead = 0; power_up_timer = 0; wdt = 0; dly = 9'h008; errors = 0; total_checks = 0;
    slp = 0;
    void'($urandom(37992));
    prim = 4'($urandom_range(15));
    cfg_pins = {2'b00, 2'b11, prim};
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    cur = 3; nxt = 3; cf = 0; req = 0;
    repeat (20) @(posedge clk);
    // timer ends after the source is up, so no start-up failure is due
    power_up_timer <= 1'b1;
    rd_ctrl();
    chk_pin("lock", 4'h1, {3'h0, q[5]});
    chk_pin("clock_sel", 4'h3, {2'h0, clock_sel});
    chk_pin("primary_sel", prim, primary_sel);
    chk_pin("osc_enable", 4'h8, osc_enable);
    bus(1'b0, ADDR_STATUS, 32'h0, 4'hF, q);
    chk_reg("status", 32'h38, q);
    chk_pin("low_power_rc_osc_run", 4'h1, {3'h0, low_power_rc_osc_run});
    w(1, 8'h02);
    rd_ctrl();
    g = 2'($urandom_range(2));
    sw(g, 1'b1);
    wait_sel(g);
    chk_pin("clock_sel", {2'h0, g}, {2'h0, clock_sel});
    cur = g; req = 0;
    rd_ctrl();
    sw(2'h3, 1'b1);
    wait_sel(2'h3);
    cur = 3; req = 0;
    rd_ctrl();
    chk_pin("primary_sel", prim, primary_sel);
    dly <= 9'h190;
    sw(2'h0, 1'b1);
    w(0, LO_KEY1);
    w(0, LO_KEY2);
    w(0, 8'h00);
    req = 0;
    rd_ctrl();
    chk_pin("clock_sel", 4'h3, {2'h0, clock_sel});
    dly <= 9'h008;
    dead <= 1'b1;
    n = 0;
    while (trap !== 1'b1 && n < 200)
    begin
      @(posedge clk);
      n++;
    end
    chk_pin("trap", 4'h1, {3'h0, trap});
    @(posedge clk);
    chk_pin("trap", 4'h0, {3'h0, trap});
    wait_sel(2'h1);
    cur = 1; cf = 1; req = 0;
    rd_ctrl();
    chk_pin("osc_enable", 4'h2, osc_enable);
    chk_pin("low_power_rc_osc_run", 4'h1, {3'h0, low_power_rc_osc_run});
    w(0, LO_KEY1);
    w(0, LO_KEY2);
    w(0, 8'h00);
    rd_ctrl();
    bus(1'b0, 4'h8, 32'h0, 4'hF, q);
    chk_reg("unmapped", 32'h0, q);
    dead <= 1'b0;
    wdt <= 1'b1;
    cfg_pins <= {2'b10, 2'b00, prim};
    repeat (3) @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    bus(1'b0, ADDR_STATUS, 32'h0, 4'hF, q);
    chk_reg("status", 32'h24, q);
    chk_pin("low_power_rc_osc_run", 4'h1, {3'h0, low_power_rc_osc_run});
    sw(2'h1, 1'b1);
    repeat (20) @(posedge clk);
    chk_pin("clock_sel", 4'h0, {2'h0, clock_sel});
    // slow start: the timer ends long before the primary source is up
    power_up_timer <= 1'b0;
    wdt <= 1'b0;
    dly <= 9'h190;
    cfg_pins <= {2'b00, 2'b11, prim};
    repeat (3) @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    power_up_timer <= 1'b1;
    n = 0;
    while (trap !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    chk_pin("trap", 4'h1, {3'h0, trap});
    cur = 1; nxt = 3; cf = 1; req = 0;
    rd_ctrl();
    chk_pin("osc_enable", 4'h2, osc_enable);
    chk_pin("low_power_rc_osc_run", 4'h1, {3'h0, low_power_rc_osc_run});
    slp <= 1'b1;
    repeat (5) @(posedge clk);
    chk_pin("low_power_rc_osc_run", 4'h0, {3'h0, low_power_rc_osc_run});
    end_sim();
  end
endmodule : testbench
`default_nettype wire
